/* dv/urf_ctl_tb_top.sv */
`default_nettype none

module urf_ctl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk      = 1'b0;
  logic                 sys_rst  = 1'b1;
  urf_pkg::urf_wb_req_t wb_req   = '0;
  logic                 tx_data  = 1'b1;
  logic                 rx_valid = 1'b0;
  logic                 rx_err   = 1'b0;
  logic                 line_bit = 1'b1;
  logic                 ir_mode  = 1'b0;
  logic [31:0]          wb_dat;
  logic                 wb_ack;
  logic                 rxd;
  logic                 ir_rxd;
  logic                 txd;
  logic                 ir_txd;
  logic                 rx_filt;
  logic                 irq;
  logic [7:0]           rd_a;
  logic [7:0]           rd_b;
  int                   errors    = 0;
  int                   tests_run = 0;

  urf_ctl urf_ctl_i (.CLK(clk), .SYS_RST(sys_rst), .WB_REQ(wb_req), .WB_DAT_O(wb_dat),
    .WB_ACK_O(wb_ack), .RXD(rxd), .IR_RXD(ir_rxd), .TX_DATA(tx_data),
    .RX_DATA_VALID(rx_valid), .RX_ERROR(rx_err), .TXD(txd), .IR_TXD(ir_txd),
    .RX_FILTERED(rx_filt), .IRQ(irq));

  urf_line_model urf_line_model_i (.LINE_BIT(line_bit), .IR_MODE(ir_mode), .CLK(clk),
    .RXD(rxd), .IR_RXD(ir_rxd));

  always #50 clk = ~clk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // ack and read data are taken at the edge, before that edge's updates land
  task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] wd,
                    output logic [7:0] rd);
    int n;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {2'h0, idx, 2'h0}, sel: 4'h1,
                dat: {24'h0, wd}};
    for (n = 0; n < 20 && wb_ack !== 1'b1; n++)
      @(posedge clk);
    rd = wb_dat[7:0];
    wb_req <= '0;
    if (n == 20)
    begin
      errors++;
      summarize;
    end
  endtask : wb

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] dummy;
    wb(1'b1, idx, d, dummy);
  endtask : wr

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    wb(1'b0, idx, 8'h00, v);
    chk("register", v, exp);
  endtask : rd_chk

  task automatic pulse(input logic err);
    @(posedge clk);
    if (err)
      rx_err <= 1'b1;
    else
      rx_valid <= 1'b1;
    @(posedge clk);
    rx_err <= 1'b0;
    rx_valid <= 1'b0;
    cyc(2);
  endtask : pulse

  task automatic test_regs;
    rd_chk(urf_pkg::IDX_CTL1, 8'h00);
    rd_chk(12'h000, 8'h00);
    wr(urf_pkg::IDX_CTRL0, 8'h20);
    rd_chk(urf_pkg::IDX_CTL1, 8'h00);
    wr(urf_pkg::IDX_CTL1, 8'hf0);
    rd_chk(urf_pkg::IDX_CTL1, 8'hf0);
    wr(urf_pkg::IDX_CTRL0, 8'h40);
    wr(urf_pkg::IDX_CTL1, 8'h00);
    rd_chk(urf_pkg::IDX_CTL1, 8'h00);
    wr(urf_pkg::IDX_CTRL0, 8'h20);
    rd_chk(urf_pkg::IDX_CTL1, 8'hf0);
    wr(urf_pkg::IDX_CTL1, 8'h00);
    wr(urf_pkg::IDX_CTRL0, 8'h00);
    rd_chk(urf_pkg::IDX_CTL1, 8'h00);
    $display("test regs done");
  endtask : test_regs

  task automatic test_irq;
    wr(urf_pkg::IDX_IRQ_MASK, 8'h07);
    pulse(1'b0);
    chk("irq data", irq, 1'b1);
    rd_chk(urf_pkg::IDX_IRQ_STAT, 8'h01);
    wr(urf_pkg::IDX_IRQ_STAT, 8'h01);
    cyc(2);
    chk("irq clear", irq, 1'b0);
    wr(urf_pkg::IDX_CTL1, 8'h02);
    pulse(1'b0);
    chk("irq suppressed", irq, 1'b0);
    pulse(1'b1);
    chk("irq error", irq, 1'b1);
    wr(urf_pkg::IDX_IRQ_STAT, 8'h07);
    wr(urf_pkg::IDX_IRQ_MASK, 8'h00);
    pulse(1'b1);
    chk("irq masked", irq, 1'b0);
    wr(urf_pkg::IDX_IRQ_STAT, 8'h07);
    wr(urf_pkg::IDX_CTL1, 8'h00);
    $display("test irq done");
  endtask : test_irq

  task automatic test_paths;
    tx_data <= 1'b0;
    line_bit <= 1'b0;
    cyc(4);
    chk("txd", txd, 1'b0);
    chk("ir txd", ir_txd, 1'b0);
    chk("rx plain", rx_filt, 1'b0);
    line_bit <= 1'b1;
    wr(urf_pkg::IDX_CTL1, 8'h01);
    ir_mode <= 1'b1;
    cyc(2);
    line_bit <= 1'b0;
    cyc(4);
    chk("txd ir", txd, 1'b1);
    chk("ir txd ir", ir_txd, 1'b1);
    chk("rx ir", rx_filt, 1'b0);
    line_bit <= 1'b1;
    wr(urf_pkg::IDX_CTL1, 8'h00);
    ir_mode <= 1'b0;
    tx_data <= 1'b1;
    cyc(4);
    $display("test paths done");
  endtask : test_paths

  // every width code: output holds until the counter runs from full to empty
  task automatic test_filter;
    int mx;
    wr(urf_pkg::IDX_CTRL0, 8'h20);
    for (int c = 0; c < 8; c++)
    begin
      mx = (1 << (4 + c)) - 1;
      wr(urf_pkg::IDX_CTL1, {1'b1, 3'(c), 4'h0});
      cyc(mx + 8);
      line_bit <= 1'b0;
      cyc(mx - 4);
      chk("filter hold", rx_filt, 1'b1);
      cyc(10);
      chk("filter fall", rx_filt, 1'b0);
      line_bit <= 1'b1;
      cyc(mx + 8);
      chk("filter rise", rx_filt, 1'b1);
    end
    wr(urf_pkg::IDX_CTL1, 8'h80);
    line_bit <= 1'b0;
    cyc(6);
    line_bit <= 1'b1;
    cyc(12);
    chk("glitch", rx_filt, 1'b1);
    wr(urf_pkg::IDX_CTL1, 8'h00);
    $display("test filter done");
  endtask : test_filter

  task automatic test_baud;
    wr(urf_pkg::IDX_CTRL0, 8'h00);
    wr(urf_pkg::IDX_BRG_HI, 8'h12);
    wr(urf_pkg::IDX_BRG_LO, 8'h34);
    wr(urf_pkg::IDX_CTRL0, 8'h01);
    rd_chk(urf_pkg::IDX_BRG_HI, 8'h12);
    rd_chk(urf_pkg::IDX_BRG_LO, 8'h34);
    wr(urf_pkg::IDX_CTL1, 8'h04);
    wb(1'b0, urf_pkg::IDX_BRG_LO, 8'h00, rd_a);
    wb(1'b0, urf_pkg::IDX_BRG_LO, 8'h00, rd_b);
    chk("live count", {7'h0, rd_a != rd_b}, 8'h01);
    rd_chk(urf_pkg::IDX_BRG_HI, 8'h12);
    wr(urf_pkg::IDX_CTL1, 8'h00);
    wr(urf_pkg::IDX_CTRL0, 8'h00);
    rd_chk(urf_pkg::IDX_BRG_LO, 8'h34);
    wr(urf_pkg::IDX_BRG_HI, 8'h00);
    wr(urf_pkg::IDX_BRG_LO, 8'h05);
    wr(urf_pkg::IDX_CTL1, 8'h04);
    cyc(20);
    rd_chk(urf_pkg::IDX_IRQ_STAT, 8'h04);
    wr(urf_pkg::IDX_CTL1, 8'h00);
    wr(urf_pkg::IDX_IRQ_STAT, 8'h07);
    $display("test baud done");
  endtask : test_baud

  initial
  begin
    cyc(3);
    sys_rst <= 1'b0;
    test_regs;
    test_irq;
    test_paths;
    test_filter;
    test_baud;
    summarize;
  end
endmodule : urf_ctl_tb_top

`default_nettype wire

/* dv/urf_line_model.sv */
`default_nettype none

module urf_line_model
(
  input  wire logic LINE_BIT,
  input  wire logic IR_MODE,
  input  wire logic CLK,
  output logic      RXD,
  output logic      IR_RXD
);
  timeunit 1ns;
  timeprecision 1ns;

  initial RXD = 1'b1;
  initial IR_RXD = 1'b0;

  // light pulse is a zero bit; the unused wire rests idle: RXD high, IR_RXD low
  always @(posedge CLK)
  begin
    RXD    <= IR_MODE ? 1'b1 : LINE_BIT;
    IR_RXD <= IR_MODE ? !LINE_BIT : 1'b0;
  end
endmodule : urf_line_model

`default_nettype wire

/* pkg/urf_pkg.sv */
`default_nettype none

package urf_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [11:0] IDX_CTRL0    = 12'hf40;
  localparam logic [11:0] IDX_CTL1     = 12'hf43;
  localparam logic [11:0] IDX_BRG_HI   = 12'hf46;
  localparam logic [11:0] IDX_BRG_LO   = 12'hf47;
  localparam logic [11:0] IDX_IRQ_STAT = 12'hf48;
  localparam logic [11:0] IDX_IRQ_MASK = 12'hf49;

  // control zero layout
  localparam int unsigned RX_EN_BIT = 0;
  localparam int unsigned VIEW_LSB  = 5;

  // shared control-one views
  localparam logic [2:0] VIEW_LOW = 3'h0;
  localparam logic [2:0] VIEW_NF  = 3'h1;

  // control-one low view layout
  localparam int unsigned RSEL_BIT = 2;
  localparam int unsigned SUPP_BIT = 1;
  localparam int unsigned IR_BIT   = 0;

  // noise filter view layout
  localparam int unsigned NF_EN_BIT = 7;
  localparam int unsigned NF_W_LSB  = 4;
  localparam logic [3:0]  NF_RSVD   = 4'h0;

  // interrupt status and mask layout
  localparam int unsigned IRQ_DATA = 0;
  localparam int unsigned IRQ_ERR  = 1;
  localparam int unsigned IRQ_BRG  = 2;

  localparam logic [10:0] FILT_FULL = 11'h7ff;
  localparam logic [2:0]  FILT_TOP  = 3'h7;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } urf_wb_req_t;

  typedef struct packed {
    logic        rx_en;
    logic [2:0]  view;
    logic [7:0]  ctl1_low;
    logic        nf_en;
    logic [2:0]  nf_width;
    logic [15:0] brg_reload;
    logic [15:0] brg_cnt;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [10:0] filt_cnt;
    logic        rx_filt;
    logic        txd;
    logic        ir_txd;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
  } urf_state_t;

  // line idles at mark, so the filtered output and the wire start high
  localparam urf_state_t URF_STATE_RST = '{rx_filt: 1'b1, txd: 1'b1, default: '0};

  function automatic logic reg_hit(input logic [15:0] adr, input logic [11:0] idx);
    reg_hit = (adr == {2'h0, idx, 2'h0});
  endfunction : reg_hit

  // saturation point of the up/down counter: code 0 is 4 bits, code 7 is 11 bits
  function automatic logic [10:0] filt_max(input logic [2:0] code);
    filt_max = FILT_FULL >> (FILT_TOP - code);
  endfunction : filt_max

endpackage : urf_pkg

`default_nettype wire

/* verilog/urf_ctl.sv */
// Behaviour
// [R1] select 0, receiver on: read reload value
// [R2] select 1, receiver on: read live count
// [R3] suppress 0: data and errors raise interrupt
// [R4] suppress 1: only receiver errors raise interrupt; the rate counter zero event is not suppressed and still raises one
// [R5] infrared off: normal transmit and receive paths
// [R6] infrared on: both paths through codec
// [R7] filter register visible only in view 001
// [R8] filter off: receive data passes unfiltered
// [R9] filter on: receive data filtered first
// [R10] width code 000..111 gives 4..11 bits
// [R11] wider counter means more delay, rejection
// [R12] low four filter bits read zero
// [R13] read select only while receiver enabled
// [R14] saturating up/down counter, output at extremes
//
// Register access over Wishbone was chosen for this implementation.
`default_nettype none

module urf_ctl
(
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  input  wire urf_pkg::urf_wb_req_t WB_REQ,
  output logic [31:0]              WB_DAT_O,
  output logic                     WB_ACK_O,
  input  wire logic                RXD,
  input  wire logic                IR_RXD,
  input  wire logic                TX_DATA,
  input  wire logic                RX_DATA_VALID,
  input  wire logic                RX_ERROR,
  output logic                     TXD,
  output logic                     IR_TXD,
  output logic                     RX_FILTERED,
  output logic                     IRQ
);

  urf_pkg::urf_state_t st_reg;
  urf_pkg::urf_state_t st_next;

  logic        req;
  logic        wr;
  logic        rd;
  logic [7:0]  wd;
  logic [31:0] rdata;
  logic [2:0]  irq_clr;
  logic [2:0]  irq_evt;
  logic        rsel;
  logic        supp;
  logic        ir_on;
  logic        brg_run;
  logic        brg_evt;
  logic        rx_src;
  logic [10:0] fmax;

  always_comb
  begin
    st_next = st_reg;
    req     = WB_REQ.cyc & WB_REQ.stb & ~st_reg.ack;
    wr      = req & WB_REQ.we & WB_REQ.sel[0];
    rd      = req & ~WB_REQ.we;
    wd      = WB_REQ.dat[7:0];
    rsel    = st_reg.ctl1_low[urf_pkg::RSEL_BIT];
    supp    = st_reg.ctl1_low[urf_pkg::SUPP_BIT];
    ir_on   = st_reg.ctl1_low[urf_pkg::IR_BIT];
    irq_clr = '0;
    rdata   = '0;

    // every strobe gets one ack, unmapped addresses included
    st_next.ack = req;

    if (wr)
    begin
      if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_CTRL0))
      begin
        st_next.rx_en = wd[urf_pkg::RX_EN_BIT];
        st_next.view  = wd[urf_pkg::VIEW_LSB +: 3];
      end
      if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_CTL1))
      begin
        if (st_reg.view == urf_pkg::VIEW_LOW)
        begin
          st_next.ctl1_low = wd;
        end
        else if (st_reg.view == urf_pkg::VIEW_NF) // R7
        begin
          st_next.nf_en    = wd[urf_pkg::NF_EN_BIT];
          st_next.nf_width = wd[urf_pkg::NF_W_LSB +: 3];
        end
      end
      if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_BRG_HI))
      begin
        st_next.brg_reload[15:8] = wd;
      end
      if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_BRG_LO))
      begin
        st_next.brg_reload[7:0] = wd;
      end
      if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_IRQ_STAT))
      begin
        irq_clr = wd[2:0];
      end
      if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_IRQ_MASK))
      begin
        st_next.irq_mask = wd[2:0];
      end
    end

    // read mux
    if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_CTRL0))
    begin
      rdata[urf_pkg::RX_EN_BIT]       = st_reg.rx_en;
      rdata[urf_pkg::VIEW_LSB +: 3]   = st_reg.view;
    end
    else if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_CTL1))
    begin
      if (st_reg.view == urf_pkg::VIEW_LOW)
      begin
        rdata[7:0] = st_reg.ctl1_low;
      end
      else if (st_reg.view == urf_pkg::VIEW_NF) // R7
      begin
        rdata[7:0] = {st_reg.nf_en, st_reg.nf_width, urf_pkg::NF_RSVD}; // R12
      end
    end
    else if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_BRG_HI))
    begin
      // live count is not latched across the two byte reads
      rdata[7:0] = (st_reg.rx_en && rsel) ? st_reg.brg_cnt[15:8] // R2
                                          : st_reg.brg_reload[15:8]; // R1
    end
    else if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_BRG_LO))
    begin
      rdata[7:0] = (st_reg.rx_en && rsel) ? st_reg.brg_cnt[7:0] // R2
                                          : st_reg.brg_reload[7:0]; // R1
    end
    else if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_IRQ_STAT))
    begin
      rdata[2:0] = st_reg.irq_stat;
    end
    else if (urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_IRQ_MASK))
    begin
      rdata[2:0] = st_reg.irq_mask;
    end
    st_next.dat = rd ? rdata : '0;

    // rate counter: idles at reload when receiver is off and select is 0
    brg_run = st_reg.rx_en | rsel; // R13
    brg_evt = ~st_reg.rx_en & rsel & (st_reg.brg_cnt == '0); // R13
    if (!brg_run)
    begin
      st_next.brg_cnt = st_reg.brg_reload;
    end
    else if (st_reg.brg_cnt == '0)
    begin
      st_next.brg_cnt = st_reg.brg_reload;
    end
    else
    begin
      st_next.brg_cnt = st_reg.brg_cnt - 16'h1;
    end

    // events; a set in the same cycle as a clear wins
    irq_evt                   = '0;
    irq_evt[urf_pkg::IRQ_DATA] = RX_DATA_VALID & ~supp; // R3 R4
    irq_evt[urf_pkg::IRQ_ERR]  = RX_ERROR; // R3 R4
    irq_evt[urf_pkg::IRQ_BRG]  = brg_evt;
    st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_evt;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

    // infrared codec: a zero bit goes out as a light pulse, line stays at mark
    st_next.txd    = ir_on ? 1'b1 : TX_DATA; // R5 R6
    st_next.ir_txd = ir_on & ~TX_DATA; // R6
    rx_src         = ir_on ? ~IR_RXD : RXD; // R5 R6

    // noise filter
    fmax = urf_pkg::filt_max(st_reg.nf_width); // R10 R11
    if (!st_reg.nf_en)
    begin
      // counter is primed to the line level so enabling causes no glitch
      st_next.filt_cnt = rx_src ? fmax : '0;
      st_next.rx_filt  = rx_src; // R8
    end
    else
    begin
      if (st_reg.filt_cnt > fmax)
      begin
        // width just narrowed: clamp rather than wrap
        st_next.filt_cnt = fmax; // R10
      end
      else if (rx_src && st_reg.filt_cnt != fmax)
      begin
        st_next.filt_cnt = st_reg.filt_cnt + 11'h1; // R14
      end
      else if (!rx_src && st_reg.filt_cnt != '0)
      begin
        st_next.filt_cnt = st_reg.filt_cnt - 11'h1; // R14
      end
      if (st_reg.filt_cnt >= fmax)
      begin
        st_next.rx_filt = 1'b1; // R9 R14
      end
      else if (st_reg.filt_cnt == '0)
      begin
        st_next.rx_filt = 1'b0; // R9 R14
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      st_reg <= urf_pkg::URF_STATE_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign WB_DAT_O    = st_reg.dat;
  assign WB_ACK_O    = st_reg.ack;
  assign TXD         = st_reg.txd;
  assign IR_TXD      = st_reg.ir_txd;
  assign RX_FILTERED = st_reg.rx_filt;
  assign IRQ         = st_reg.irq;

  default clocking urf_cb @(posedge CLK);
  endclocking

  default disable iff (SYS_RST);

  a_reload_read: assert property ( // R1
    rd && urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_BRG_LO) && st_reg.rx_en && !rsel
    |=> WB_ACK_O && WB_DAT_O == {24'h0, $past(st_reg.brg_reload[7:0])})
    else $error("reload value not returned");

  a_count_read: assert property ( // R2
    rd && urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_BRG_HI) && st_reg.rx_en && rsel
    |=> WB_ACK_O && WB_DAT_O[7:0] == $past(st_reg.brg_cnt[15:8]))
    else $error("live count not returned");

  a_data_irq_set: assert property ( // R3
    RX_DATA_VALID && !supp |=> st_reg.irq_stat[urf_pkg::IRQ_DATA])
    else $error("received data did not set status");

  a_data_irq_blocked: assert property ( // R4
    supp && !st_reg.irq_stat[urf_pkg::IRQ_DATA] |=> !st_reg.irq_stat[urf_pkg::IRQ_DATA])
    else $error("suppressed data raised status");

  a_error_irq: assert property ( // R4
    RX_ERROR && st_reg.irq_mask[urf_pkg::IRQ_ERR] |=> IRQ && st_reg.irq_stat[urf_pkg::IRQ_ERR])
    else $error("receiver error did not raise irq");

  a_plain_path: assert property ( // R5
    !ir_on |=> TXD == $past(TX_DATA) && !IR_TXD)
    else $error("normal transmit path broken");

  a_ir_path: assert property ( // R6
    ir_on |=> TXD && IR_TXD == !$past(TX_DATA))
    else $error("infrared transmit path broken");

  a_view_gate: assert property ( // R7
    rd && urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_CTL1)
    && st_reg.view != urf_pkg::VIEW_LOW && st_reg.view != urf_pkg::VIEW_NF
    |=> WB_DAT_O == 32'h0)
    else $error("control-one read outside known view");

  a_nf_read: assert property ( // R12
    rd && urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_CTL1) && st_reg.view == urf_pkg::VIEW_NF
    |=> WB_DAT_O[3:0] == 4'h0 && WB_DAT_O[7] == $past(st_reg.nf_en))
    else $error("filter register read wrong");

  a_filter_bypass: assert property ( // R8
    !st_reg.nf_en |=> RX_FILTERED == $past(rx_src))
    else $error("bypass output differs from line");

  a_filter_bound: assert property ( // R10
    st_reg.nf_en && $stable(st_reg.nf_width) |-> st_reg.filt_cnt <= fmax)
    else $error("filter counter beyond selected width");

  a_filter_hold: assert property ( // R14
    st_reg.nf_en && st_reg.filt_cnt != '0 && st_reg.filt_cnt < fmax
    && $stable(st_reg.nf_en) |=> RX_FILTERED == $past(RX_FILTERED))
    else $error("filtered output moved between extremes");

  a_filter_delay: assert property ( // R9
    st_reg.nf_en && st_reg.nf_width == 3'h0 && st_reg.filt_cnt == '0 && !RX_FILTERED
    ##1 (rx_src && st_reg.nf_en && $stable(st_reg.nf_width)) [*3]
    |=> !RX_FILTERED)
    else $error("short pulse passed the filter");

  a_brg_idle: assert property ( // R13
    !st_reg.rx_en && !rsel |=> st_reg.brg_cnt == $past(st_reg.brg_reload))
    else $error("rate counter ran while disabled");

  a_brg_event: assert property ( // R13
    !st_reg.rx_en && rsel && st_reg.brg_cnt == '0 |=> st_reg.irq_stat[urf_pkg::IRQ_BRG])
    else $error("rate counter zero did not set status");

  a_count_read_lo: assert property ( // R2
    rd && urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_BRG_LO) && st_reg.rx_en && rsel
    |=> WB_ACK_O && WB_DAT_O[7:0] == $past(st_reg.brg_cnt[7:0]))
    else $error("live low count not returned");

  a_ack_single: assert property ( // R1
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");

  a_dat_idle: assert property ( // R1
    !WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack cycle");

  a_err_set: assert property ( // R3
    RX_ERROR |=> st_reg.irq_stat[urf_pkg::IRQ_ERR])
    else $error("receiver error did not set status");

  a_stat_sticky: assert property ( // R4
    st_reg.irq_stat[urf_pkg::IRQ_ERR]
    && !(wr && urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_IRQ_STAT) && wd[urf_pkg::IRQ_ERR])
    |=> st_reg.irq_stat[urf_pkg::IRQ_ERR])
    else $error("error status lost without clear");

  a_irq_level: assert property ( // R3
    1'b1 |-> IRQ == |(st_reg.irq_stat & st_reg.irq_mask))
    else $error("irq level differs from status and mask");

  a_plain_receive: assert property ( // R5
    !ir_on && !st_reg.nf_en |=> RX_FILTERED == $past(RXD))
    else $error("normal receive path broken");

  a_ir_receive: assert property ( // R6
    ir_on && !st_reg.nf_en |=> RX_FILTERED == !$past(IR_RXD))
    else $error("infrared receive path broken");

  a_filter_rise: assert property ( // R14
    st_reg.nf_en && st_reg.filt_cnt >= fmax |=> RX_FILTERED)
    else $error("full filter counter did not raise output");

  a_filter_fall: assert property ( // R14
    st_reg.nf_en && st_reg.filt_cnt == '0 |=> !RX_FILTERED)
    else $error("empty filter counter did not lower output");

  a_view_write: assert property ( // R7
    wr && urf_pkg::reg_hit(WB_REQ.adr, urf_pkg::IDX_CTL1)
    && st_reg.view != urf_pkg::VIEW_LOW && st_reg.view != urf_pkg::VIEW_NF
    |=> $stable(st_reg.ctl1_low) && $stable(st_reg.nf_en) && $stable(st_reg.nf_width))
    else $error("control-one write landed outside known view");

endmodule : urf_ctl

`default_nettype wire
